/* File: btf_fault_status.sv */
`timescale 1ns/1ps
// Functional notes
// [R1] top scale codes: 0x76 95.5, 0x7f 100
// [R2] scale code steps half percent, zero is 36.5
// [R3] open flags per string at bits 7:4
// [R4] short flags per string at bits 3:0
// [R5] short flags refreshed every dimming cycle
// [R6] boost undervoltage sets supply bit 7
// [R7] boost overvoltage sets supply bit 6
// [R8] overvoltage stops switching, converter stays enabled
// [R9] string short to ground sets bit 5
// [R10] boost event flags stay latched once set
// [R11] undervoltage flags immediately; 50ms turns off
// [R12] source high overload sets bit 3
// [R13] read only, writes ignored, zero after reset
module btf_fault_status
    import btf_pkg::*;
#(
    parameter int UV_CYCLES = UV_OFF_CYCLES    // shorten in simulation
)(
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_ce,              // clock enable
    input  wire logic [6:0] i_current_scale,   // led current scale code
    input  wire logic       i_dim_cycle,       // pulse at dimming cycle start
    input  wire logic [3:0] i_open_det,        // open string detectors
    input  wire logic [3:0] i_short_det,       // shorted led detectors
    input  wire logic       i_boost_uv,        // boost undervoltage
    input  wire logic       i_boost_ov,        // boost overvoltage
    input  wire logic       i_boost_en,        // boost enabled by control
    input  wire logic       i_short_gnd,       // string shorted to ground
    input  wire logic       i_src_hi_uv,       // source high undervoltage
    input  wire logic       i_source_high_overload,
    input  wire logic       i_src_lo_uv,       // source_low_rail undervoltage
    input  wire logic       i_gate_hi_uv,      // gate_high_rail undervoltage
    input  wire logic       i_gate_lo_uv,      // gate low rail undervoltage
    input  wire logic       i_rd,              // register read strobe
    input  wire logic       i_wr,              // register write strobe
    input  wire logic [7:0] i_addr,            // register address
    input  wire logic [7:0] i_wdata,           // write data, unused
    output logic [7:0]      o_rdata,           // read data
    output logic [9:0]      o_scale_permille,  // current in per-mille
    output logic            o_boost_switch,    // boost switching allowed
    output logic            o_boost_enabled,   // boost converter enabled
    output logic [3:0]      o_rail_off         // src hi, src lo, gate hi, gate lo
);
    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [1:0] {
        BTF_IDLE = 2'b01,    // no read
        BTF_RD   = 2'b10     // read presented
    } btf_state_t;

    btf_state_t state, next_state;       // read port state
    logic [7:0] string_faults;           // backlight_string_faults
    logic [7:0] next_string_faults;
    logic [7:0] supply_hi;               // latched bits 7:5 and 3
    logic [7:0] next_supply_hi;
    logic [7:0] supply_fault_flags;      // assembled register
    logic [7:0] next_rdata;
    logic [9:0] next_scale;
    logic       next_switch;
    logic [3:0] uv_flag;                 // timer flags
    logic [3:0] uv_off;                  // timer shutdowns
    logic [3:0] uv_in;                   // timer inputs

    assign uv_in = {i_src_hi_uv, i_src_lo_uv, i_gate_hi_uv, i_gate_lo_uv};

    // ************************************************************
    // undervoltage timers, one per rail
    // ************************************************************
    for (genvar g = 0; g < 4; g++)
    begin : g_uv
        btf_uv_timer #(.OFF_CYCLES(UV_CYCLES)) u_uv (
            .i_clk   (i_clk),
            .i_reset (i_reset),
            .i_ce    (i_ce),
            .i_uv    (uv_in[g]),
            .o_flag  (uv_flag[g]),
            .o_off   (uv_off[g])
        );
    end

    // register assembly
    always_comb
    begin
        supply_fault_flags = supply_hi;
        supply_fault_flags[BIT_SRC_HI_UV]  = uv_flag[3];
        supply_fault_flags[BIT_SRC_LO_UV]  = uv_flag[2];
        supply_fault_flags[BIT_GATE_HI_UV] = uv_flag[1];
        supply_fault_flags[BIT_GATE_LO_UV] = uv_flag[0];
    end

    // ************************************************************
    // fault next values
    // ************************************************************
    always_comb
    begin
        next_string_faults = string_faults;
        next_supply_hi     = supply_hi;
        // [R3] open flags latch per string
        next_string_faults[OPEN_LSB +: 4] = string_faults[OPEN_LSB +: 4] | i_open_det;
        // [R5] short flags refresh each dim cycle
        if (i_dim_cycle)
        begin
            // [R4] short flag per string
            next_string_faults[SHORT_LSB +: 4] = i_short_det;
        end
        // [R6] [R10] boost undervoltage latched
        if (i_boost_uv)
        begin
            next_supply_hi[BIT_BOOST_UV] = 1'b1;
        end
        // [R7] [R10] boost overvoltage latched
        if (i_boost_ov)
        begin
            next_supply_hi[BIT_BOOST_OV] = 1'b1;
        end
        // [R9] short to ground
        if (i_short_gnd)
        begin
            next_supply_hi[BIT_SHORT_GND] = 1'b1;
        end
        // [R12] source high overload
        if (i_source_high_overload)
        begin
            next_supply_hi[BIT_SRC_HI_OL] = 1'b1;
        end
        next_supply_hi[4:0] = {1'b0, next_supply_hi[3], 3'h0};
    end

    // ************************************************************
    // read port and outputs next values
    // ************************************************************
    always_comb
    begin
        next_state = BTF_IDLE;
        next_rdata = 8'h00;
        // [R13] reads only, writes fall through
        if (i_rd && i_addr == ADDR_STRING_FAULTS)
        begin
            next_state = BTF_RD;
            next_rdata = string_faults;
        end
        else if (i_rd && i_addr == ADDR_SUPPLY_FAULTS)
        begin
            next_state = BTF_RD;
            next_rdata = supply_fault_flags;
        end
        // [R8] overvoltage stops switching only
        next_switch = i_boost_en && !i_boost_ov;
        // [R1] [R2] scale decode in half percents
        next_scale = SCALE_BASE_PERMILLE + 10'(i_current_scale) * SCALE_STEP_PERMILLE;
    end

    // registers
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            // [R13] fault registers and read data zero after reset; scale loads base 365
            state            <= BTF_IDLE;
            string_faults    <= RST_STRING_FAULTS;
            supply_hi        <= RST_SUPPLY_FAULTS;
            o_rdata          <= 8'h00;
            o_scale_permille <= SCALE_BASE_PERMILLE;
            o_boost_switch   <= 1'b0;
            o_boost_enabled  <= 1'b0;
            o_rail_off       <= 4'h0;
        end
        else if (i_ce)
        begin
            state            <= next_state;
            string_faults    <= next_string_faults;
            supply_hi        <= next_supply_hi;
            o_rdata          <= next_rdata;
            o_scale_permille <= next_scale;
            o_boost_switch   <= next_switch;
            o_boost_enabled  <= i_boost_en;
            o_rail_off       <= uv_off;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    AST_SCALE_TOP: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && i_current_scale == 7'h7f |=> o_scale_permille == 10'h3e8) // [R1]
        else $error("scale top not 100 percent");
    AST_SCALE_ZERO: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && i_current_scale == 7'h00 |=> o_scale_permille == 10'h16d) // [R2]
        else $error("scale zero not 36.5 percent");
    AST_OPEN: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && i_open_det[0] |=> string_faults[4]) // [R3]
        else $error("open flag missing");
    AST_SHORT: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && i_dim_cycle |=> string_faults[3:0] == $past(i_short_det)) // [R4]
        else $error("short flags not refreshed");
    AST_SHORT_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && !i_dim_cycle |=> $stable(string_faults[3:0])) // [R5]
        else $error("short flags changed outside dim cycle");
    AST_BOOST_UV: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && i_boost_uv |=> supply_fault_flags[7]) // [R6]
        else $error("boost uv not set");
    AST_OV_SWITCH: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && i_boost_ov && i_boost_en |=> !o_boost_switch && o_boost_enabled) // [R8]
        else $error("ov did not stop switching");
    AST_LATCH: assert property (@(posedge i_clk) disable iff (i_reset)
        supply_fault_flags[6] |=> supply_fault_flags[6]) // [R10]
        else $error("ov flag lost");
    AST_READ: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && i_rd && i_addr == 8'h08 |=> o_rdata == $past(supply_fault_flags)) // [R13]
        else $error("supply read wrong");
    AST_GND: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && i_short_gnd |=> supply_fault_flags[5]) // [R9]
        else $error("short gnd not set");
    AST_BOOST_OV: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && i_boost_ov |=> supply_fault_flags[BIT_BOOST_OV]) // [R7]
        else $error("boost ov not set");
    AST_SRC_OL: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && i_source_high_overload |=> supply_fault_flags[BIT_SRC_HI_OL]) // [R12]
        else $error("source overload not set");
    AST_WR_IGNORED: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && i_wr && !i_rd && i_wdata != 8'h00 |=> o_rdata == 8'h00) // [R13]
        else $error("write left a trace on read data");
    COV_READ: cover property (@(posedge i_clk) state == BTF_RD);
    COV_OV: cover property (@(posedge i_clk) supply_fault_flags[6]);
    COV_OFF: cover property (@(posedge i_clk) o_rail_off != 4'h0);
endmodule

/* File: btf_host_model.sv */
`timescale 1ns/1ps
// ********************************************
// register host: drives at the falling edge
// ********************************************
module btf_host_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    output logic            o_rd,
    output logic            o_wr,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wdata
);
    initial
    begin
        o_rd    = 1'b0;
        o_wr    = 1'b0;
        o_addr  = 8'h00;
        o_wdata = 8'h00;
    end
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge i_clk);
        o_rd   = 1'b1;
        o_addr = addr;
        @(negedge i_clk);
        o_rd   = 1'b0;
        o_addr = ~addr;    // released bus shows junk
        data   = i_rdata;  // answer stands this cycle only
    endtask
    // stray write the device must drop
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge i_clk);
        o_wr    = 1'b1;
        o_addr  = addr;
        o_wdata = data;
        @(negedge i_clk);
        o_wr    = 1'b0;
        o_wdata = ~data;
    endtask
endmodule

/* File: btf_pkg.sv */
package btf_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] ADDR_STRING_FAULTS = 8'h07;   // backlight_string_faults
    localparam logic [7:0] ADDR_SUPPLY_FAULTS = 8'h08;   // supply_fault_flags
    localparam logic [7:0] RST_STRING_FAULTS  = 8'h00;   // reset value
    localparam logic [7:0] RST_SUPPLY_FAULTS  = 8'h00;   // reset value
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int OPEN_LSB      = 4;   // open flags at 7:4
    localparam int SHORT_LSB     = 0;   // short flags at 3:0
    localparam int BIT_BOOST_UV  = 7;
    localparam int BIT_BOOST_OV  = 6;
    localparam int BIT_SHORT_GND = 5;
    localparam int BIT_SRC_HI_UV = 4;
    localparam int BIT_SRC_HI_OL = 3;
    localparam int BIT_SRC_LO_UV = 2;
    localparam int BIT_GATE_HI_UV = 1;
    localparam int BIT_GATE_LO_UV = 0;
    // ************************************************************
    // current scale: per-mille, 36.5% at code 0, 0.5% steps
    // ************************************************************
    localparam logic [9:0] SCALE_BASE_PERMILLE = 10'h16d;  // 365
    localparam logic [9:0] SCALE_STEP_PERMILLE = 10'h005;  // 5
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ       = 125;
    localparam int UV_OFF_MS     = 50;
    localparam int UV_OFF_CYCLES = UV_OFF_MS * 1000 * CLK_MHZ;  // 6250000
endpackage

/* File: btf_uv_timer.sv */
`timescale 1ns/1ps
// ************************************************************
// one undervoltage flag with persistence shutdown
// ************************************************************
module btf_uv_timer
    import btf_pkg::*;
#(
    parameter int OFF_CYCLES = UV_OFF_CYCLES
)(
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_ce,
    input  wire logic i_uv,      // undervoltage present now
    output logic      o_flag,    // latched undervoltage flag
    output logic      o_off      // output turned off
);
    logic [22:0] cnt;             // persistence counter
    logic [22:0] next_cnt;
    logic        next_flag;
    logic        next_off;

    // next values
    always_comb
    begin
        next_cnt  = cnt;
        next_flag = o_flag;
        next_off  = o_off;
        // [R11] set flag at once
        if (i_uv)
        begin
            next_flag = 1'b1;
        end
        // [R11] shutdown after uninterrupted time
        if (!i_uv)
        begin
            next_cnt = '0;
        end
        else if (cnt >= 23'(OFF_CYCLES - 1))
        begin
            next_off = 1'b1;
        end
        else
        begin
            next_cnt = cnt + 23'h000001;
        end
    end

    // registers
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            cnt    <= '0;
            o_flag <= 1'b0;
            o_off  <= 1'b0;
        end
        else if (i_ce)
        begin
            cnt    <= next_cnt;
            o_flag <= next_flag;
            o_off  <= next_off;
        end
    end

    // [R11] flag latches on cause
    AST_UV_FLAG: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && i_uv |=> o_flag) // [R11]
        else $error("uv flag not set");
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench
    import btf_pkg::*;
;
    localparam int UV_SIM = 20;  // shortened persistence count
    logic       i_clk = 1'b0;
    logic       i_reset = 1'b1;
    logic       i_ce = 1'b1;
    logic [6:0] i_current_scale = 7'h00;
    logic       i_dim_cycle, i_boost_uv, i_boost_ov, i_boost_en, i_short_gnd;
    logic       i_src_hi_uv, i_source_high_overload, i_src_lo_uv, i_gate_hi_uv, i_gate_lo_uv;
    logic [3:0] i_open_det, i_short_det, o_rail_off;
    logic       i_rd, i_wr, o_boost_switch, o_boost_enabled;
    logic [7:0] i_addr, i_wdata, o_rdata;
    logic [9:0] o_scale_permille;
    int         checks = 0;
    int         fail_count = 0;
    int         cycles = 0;
    always #4 i_clk = ~i_clk;
    btf_fault_status #(.UV_CYCLES(UV_SIM)) DUT (.i_clk, .i_reset, .i_ce, .i_current_scale,
        .i_dim_cycle, .i_open_det, .i_short_det, .i_boost_uv, .i_boost_ov, .i_boost_en,
        .i_short_gnd, .i_src_hi_uv, .i_source_high_overload, .i_src_lo_uv, .i_gate_hi_uv,
        .i_gate_lo_uv, .i_rd, .i_wr, .i_addr, .i_wdata, .o_rdata, .o_scale_permille,
        .o_boost_switch, .o_boost_enabled, .o_rail_off);
    btf_host_model host (.i_clk(i_clk), .i_rdata(o_rdata), .o_rd(i_rd), .o_wr(i_wr),
        .o_addr(i_addr), .o_wdata(i_wdata));
    // ********************************************
    // helpers
    // ********************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(addr, d);
        check({8'h00, d}, {8'h00, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // quiet detectors, reset held three cycles
    task automatic do_reset;
        @(negedge i_clk);
        {i_dim_cycle, i_boost_uv, i_boost_ov, i_boost_en, i_short_gnd} = 5'h00;
        {i_src_hi_uv, i_source_high_overload, i_src_lo_uv, i_gate_hi_uv, i_gate_lo_uv} = 5'h00;
        {i_open_det, i_short_det} = 8'h00;
        i_reset = 1'b1;
        cyc(3);
        i_reset = 1'b0;
    endtask
    // ********************************************
    // scenarios
    // ********************************************
    task automatic t_regs;
        do_reset();
        host.write_reg(ADDR_STRING_FAULTS, 8'hff);
        host.write_reg(ADDR_SUPPLY_FAULTS, 8'hff);
        rd_chk(ADDR_STRING_FAULTS, 8'h00);
        rd_chk(ADDR_SUPPLY_FAULTS, 8'h00);
        rd_chk(8'h09, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_scale;
        logic [6:0] code [4] = '{7'h00, 7'h01, 7'h76, 7'h7f};
        logic [9:0] pm [4] = '{10'h16d, 10'h172, 10'h3bb, 10'h3e8};
        for (int k = 0; k < 4; k++)
        begin
            i_current_scale = code[k];
            cyc(2);
            check({6'h00, o_scale_permille}, {6'h00, pm[k]});
        end
        $display("test scale done");
    endtask
    task automatic t_string;
        do_reset();
        {i_open_det, i_short_det, i_dim_cycle} = {8'ha5, 1'b1};
        cyc(1);
        {i_open_det, i_short_det, i_dim_cycle} = {8'h03, 1'b0};
        cyc(2);
        rd_chk(ADDR_STRING_FAULTS, 8'ha5);
        i_dim_cycle = 1'b1;
        cyc(1);
        i_dim_cycle = 1'b0;
        cyc(2);
        rd_chk(ADDR_STRING_FAULTS, 8'ha3);
        $display("test strings done");
    endtask
    task automatic t_supply;
        do_reset();
        i_boost_en = 1'b1;
        cyc(2);
        check({15'h0, o_boost_switch}, 16'h0001);
        {i_boost_uv, i_boost_ov, i_short_gnd, i_source_high_overload} = 4'hf;
        cyc(2);
        check({14'h0, o_boost_switch, o_boost_enabled}, 16'h0001);
        {i_boost_uv, i_boost_ov, i_short_gnd, i_source_high_overload} = 4'h0;
        cyc(2);
        check({15'h0, o_boost_switch}, 16'h0001);
        rd_chk(ADDR_SUPPLY_FAULTS, 8'he8);
        rd_chk(ADDR_SUPPLY_FAULTS, 8'he8);
        i_boost_en = 1'b0;
        cyc(2);
        check({14'h0, o_boost_switch, o_boost_enabled}, 16'h0000);
        $display("test supply done");
    endtask
    task automatic t_uv;
        do_reset();
        i_gate_lo_uv = 1'b1;
        cyc(UV_SIM - 1);
        i_gate_lo_uv = 1'b0;
        cyc(2);
        rd_chk(ADDR_SUPPLY_FAULTS, 8'h01);
        check({12'h0, o_rail_off}, 16'h0000);
        i_src_hi_uv = 1'b1;
        cyc(UV_SIM + 3);
        i_src_hi_uv = 1'b0;
        cyc(2);
        check({12'h0, o_rail_off}, 16'h0008);
        rd_chk(ADDR_SUPPLY_FAULTS, 8'h11);
        $display("test undervoltage done");
    endtask
    // clock enable low freezes the string and supply flags and the scale output
    task automatic t_hold;
        do_reset();
        i_current_scale = 7'h7f;
        cyc(2);
        i_ce = 1'b0;
        {i_open_det, i_short_det, i_dim_cycle} = {8'hff, 1'b1};
        {i_boost_uv, i_boost_ov, i_short_gnd, i_source_high_overload} = 4'hf;
        i_current_scale = 7'h00;
        cyc(3);
        check({6'h00, o_scale_permille}, {6'h00, 10'h3e8});
        {i_open_det, i_short_det, i_dim_cycle} = 9'h000;
        {i_boost_uv, i_boost_ov, i_short_gnd, i_source_high_overload} = 4'h0;
        i_ce = 1'b1;
        cyc(1);
        rd_chk(ADDR_STRING_FAULTS, 8'h00);
        rd_chk(ADDR_SUPPLY_FAULTS, 8'h00);
        check({6'h00, o_scale_permille}, {6'h00, 10'h16d});
        $display("test clock enable done");
    endtask
    // hang guard
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            close_out();
        end
    end
    initial
    begin
        t_regs();
        t_scale();
        t_string();
        t_supply();
        t_uv();
        t_hold();
        close_out();
    end
endmodule
